/* File: hw/radio_mode_pkg.sv */
/*
  Package for the radio operating-mode controller: register map, field positions,
  reset values, timing figures and the mode enumeration.
  Assumes a 100 MHz system clock and a plain strobe register port.
*/
package radio_mode_pkg;

  localparam int CLK_MHZ = 100;

  // Register word addresses on the plain register port.
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_TX_LOAD = 4'h2;
  localparam logic [3:0] ADDR_RX_POP = 4'h3;

  // Control register field positions.
  localparam int CTRL_POWER_UP = 0;
  localparam int CTRL_PRIMARY_RX = 1;
  localparam int CTRL_AUTO_PROTO = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status register field positions.
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_POWER_FLAG = 4;
  localparam int STAT_TX_EMPTY = 5;
  localparam int STAT_RX_FULL = 6;
  localparam int STAT_RX_DROP = 7;

  // Timing figures in their own units, and derived cycle counts.
  localparam int POR_MIN_US = 1000;
  localparam int POR_MAX_US = 100000;
  localparam int POR_CYCLES = POR_MIN_US * CLK_MHZ;
  localparam int SETTLE_MAX_US = 130;
  localparam int SETTLE_CYCLES = SETTLE_MAX_US * CLK_MHZ;
  localparam int POWER_FILTER_US = 40;
  localparam int POWER_FILTER_CYCLES = POWER_FILTER_US * CLK_MHZ;
  localparam int ACTIVATE_PULSE_NS = 10000;
  localparam int ACTIVATE_PULSE_CYCLES = (ACTIVATE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int TX_LIMIT_US = 4000;
  localparam int TX_LIMIT_CYCLES = TX_LIMIT_US * CLK_MHZ;
  localparam int RX_SLOTS = 3;
  localparam int TX_SLOTS = 3;

  typedef enum logic [2:0] {
    MODE_POR,
    MODE_POWER_DOWN,
    MODE_STANDBY1,
    MODE_STANDBY2,
    MODE_RX_SETTLE,
    MODE_RX,
    MODE_TX_SETTLE,
    MODE_TX
  } mode_e;

  typedef struct packed {
    logic auto_proto;
    logic primary_rx;
    logic power_up;
  } control_s;

endpackage

/* File: hw/radio_mode_controller.sv */
/*
  Operating-mode state machine of a packet radio: power-on reset, power-down,
  two standby levels, receive and transmit, plus the received-power flag filter.
  Assumes the activate pin and the radio detect inputs are asynchronous pins,
  and that the datapath reports packet events as single-cycle pulses.
*/
`timescale 1ns/10ps
module radio_mode_controller #(
  parameter int POR_COUNT = radio_mode_pkg::POR_CYCLES,
  parameter int SETTLE_COUNT = radio_mode_pkg::SETTLE_CYCLES,
  parameter int FILTER_COUNT = radio_mode_pkg::POWER_FILTER_CYCLES,
  parameter int TX_LIMIT_COUNT = radio_mode_pkg::TX_LIMIT_CYCLES
) (
  // Clock, reset and enable.
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_enable,
  // Register port.
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [7:0] o_rdata,
  // Pins.
  input wire logic i_activate,
  input wire logic i_power_detect,
  // Radio datapath events.
  input wire logic i_rx_packet,
  input wire logic i_rx_addr_match,
  input wire logic i_rx_crc_ok,
  input wire logic i_tx_done,
  // Mode outputs.
  output radio_mode_pkg::mode_e o_mode,
  output logic o_radio_on,
  output logic o_tx_start,
  output logic o_received_power_flag
);

  localparam int SLOT_W = 2;

  radio_mode_pkg::mode_e mode_q, mode_d;
  radio_mode_pkg::control_s ctrl_q;
  logic [1:0] act_sync_q, pwr_sync_q;
  logic [31:0] timer_q, timer_d;
  logic [31:0] act_high_q;
  logic [31:0] filt_q;
  logic [31:0] tx_time_q;
  logic [SLOT_W-1:0] tx_count_q, rx_count_q;
  logic rx_drop_q, power_flag_q, tx_start_q;
  logic [7:0] rdata_q;

  wire logic act_pin = act_sync_q[1];
  wire logic pwr_pin = pwr_sync_q[1];
  wire logic wr_ctrl = i_enable && i_write && (i_addr == radio_mode_pkg::ADDR_CONTROL);
  wire logic wr_load = i_enable && i_write && (i_addr == radio_mode_pkg::ADDR_TX_LOAD);
  wire logic rd_pop = i_enable && i_read && (i_addr == radio_mode_pkg::ADDR_RX_POP);
  wire logic tx_empty = (tx_count_q == '0);
  wire logic tx_full = (tx_count_q == SLOT_W'(radio_mode_pkg::TX_SLOTS));
  wire logic rx_full = (rx_count_q == SLOT_W'(radio_mode_pkg::RX_SLOTS));
  wire logic rx_valid = i_rx_packet && i_rx_addr_match && i_rx_crc_ok && (mode_q == radio_mode_pkg::MODE_RX);
  wire logic rx_store = rx_valid && !rx_full;
  wire logic tx_load = wr_load && !tx_full;
  wire logic tx_pop = i_tx_done && (mode_q == radio_mode_pkg::MODE_TX);
  wire logic pulse_ok = act_high_q >= 32'(radio_mode_pkg::ACTIVATE_PULSE_CYCLES);
  wire logic tx_overrun = ctrl_q.auto_proto && (tx_time_q >= 32'(TX_LIMIT_COUNT - 1));
  wire logic settled = (timer_q >= 32'(SETTLE_COUNT - 1));

  // Pin synchronisers.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      act_sync_q <= 2'h0;
      pwr_sync_q <= 2'h0;
    end else if (i_enable) begin
      act_sync_q <= {act_sync_q[0], i_activate};
      pwr_sync_q <= {pwr_sync_q[0], i_power_detect};
    end
  end

  // Next-mode logic.
  always_comb begin
    mode_d = mode_q;
    timer_d = timer_q + 32'h1;
    unique case (mode_q)
      radio_mode_pkg::MODE_POR: begin
        if (timer_q >= 32'(POR_COUNT - 1)) begin
          mode_d = radio_mode_pkg::MODE_POWER_DOWN;
        end
      end
      radio_mode_pkg::MODE_POWER_DOWN: begin
        if (ctrl_q.power_up) begin
          mode_d = radio_mode_pkg::MODE_STANDBY1;
        end
      end
      radio_mode_pkg::MODE_STANDBY1: begin
        if (act_pin && ctrl_q.primary_rx) begin
          mode_d = radio_mode_pkg::MODE_RX_SETTLE;
        end else if (act_pin && !ctrl_q.primary_rx && !tx_empty && pulse_ok) begin
          mode_d = radio_mode_pkg::MODE_TX_SETTLE;
        end else if (act_pin && !ctrl_q.primary_rx && tx_empty) begin
          mode_d = radio_mode_pkg::MODE_STANDBY2;
        end
      end
      radio_mode_pkg::MODE_STANDBY2: begin
        if (!act_pin) begin
          mode_d = radio_mode_pkg::MODE_STANDBY1;
        end else if (ctrl_q.primary_rx) begin
          mode_d = radio_mode_pkg::MODE_RX_SETTLE;
        end else if (!tx_empty) begin
          mode_d = radio_mode_pkg::MODE_TX_SETTLE;
        end
      end
      radio_mode_pkg::MODE_RX_SETTLE: begin
        if (!act_pin) begin
          mode_d = radio_mode_pkg::MODE_STANDBY1;
        end else if (settled) begin
          mode_d = radio_mode_pkg::MODE_RX;
        end
      end
      radio_mode_pkg::MODE_RX: begin
        if (!act_pin) begin
          mode_d = radio_mode_pkg::MODE_STANDBY1;
        end else if (!ctrl_q.primary_rx && !tx_empty) begin
          mode_d = radio_mode_pkg::MODE_TX_SETTLE;
        end else if (!ctrl_q.primary_rx) begin
          mode_d = radio_mode_pkg::MODE_STANDBY2;
        end
      end
      radio_mode_pkg::MODE_TX_SETTLE: begin
        if (settled) begin
          mode_d = radio_mode_pkg::MODE_TX;
        end
      end
      radio_mode_pkg::MODE_TX: begin
        if (tx_pop || tx_overrun) begin
          if (!act_pin) begin
            mode_d = radio_mode_pkg::MODE_STANDBY1;
          end else if (ctrl_q.primary_rx) begin
            mode_d = radio_mode_pkg::MODE_RX_SETTLE;
          end else if (tx_count_q > SLOT_W'(1) && !tx_overrun) begin
            mode_d = radio_mode_pkg::MODE_TX;
          end else begin
            mode_d = radio_mode_pkg::MODE_STANDBY2;
          end
        end
      end
    endcase
    if (mode_q != radio_mode_pkg::MODE_POR && !ctrl_q.power_up) begin
      mode_d = radio_mode_pkg::MODE_POWER_DOWN;
    end
    if (mode_d != mode_q) begin
      timer_d = 32'h0;
    end
  end

  // Mode register and its timers.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      mode_q <= radio_mode_pkg::MODE_POR;
      timer_q <= 32'h0;
    end else if (i_enable) begin
      mode_q <= mode_d;
      timer_q <= timer_d;
    end
  end

  // Activate-pin high time and transmit dwell time.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      act_high_q <= 32'h0;
      tx_time_q <= 32'h0;
    end else if (i_enable) begin
      act_high_q <= act_pin ? act_high_q + 32'h1 : 32'h0;
      tx_time_q <= (mode_q == radio_mode_pkg::MODE_TX && mode_d == radio_mode_pkg::MODE_TX
                    && !tx_pop) ? tx_time_q + 32'h1 : 32'h0;
    end
  end

  // Control register; kept in every mode, including power-down.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= radio_mode_pkg::control_s'(radio_mode_pkg::CTRL_RESET[2:0]);
    end else if (wr_ctrl) begin
      ctrl_q.power_up <= i_wdata[radio_mode_pkg::CTRL_POWER_UP];
      ctrl_q.primary_rx <= i_wdata[radio_mode_pkg::CTRL_PRIMARY_RX];
      ctrl_q.auto_proto <= i_wdata[radio_mode_pkg::CTRL_AUTO_PROTO];
    end
  end

  // Transmit and receive slot occupancy.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tx_count_q <= '0;
      rx_count_q <= '0;
      rx_drop_q <= 1'b0;
    end else if (i_enable) begin
      tx_count_q <= tx_count_q + SLOT_W'(tx_load) - SLOT_W'(tx_pop && !tx_empty);
      rx_count_q <= rx_count_q + SLOT_W'(rx_store) - SLOT_W'(rd_pop && rx_count_q != '0);
      if (rx_valid && rx_full) begin
        rx_drop_q <= 1'b1;
      end else if (rd_pop) begin
        rx_drop_q <= 1'b0;
      end
    end
  end

  // Received-power filter: flag rises after a sustained strong signal in receive mode.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      filt_q <= 32'h0;
      power_flag_q <= 1'b0;
    end else if (i_enable) begin
      if (mode_q == radio_mode_pkg::MODE_RX && pwr_pin) begin
        filt_q <= (filt_q < 32'(FILTER_COUNT)) ? filt_q + 32'h1 : filt_q;
      end else begin
        filt_q <= 32'h0;
      end
      if (mode_q == radio_mode_pkg::MODE_RX) begin
        power_flag_q <= pwr_pin && (filt_q >= 32'(FILTER_COUNT - 1));
      end
    end
  end

  // Transmit start pulse on entering transmit mode and on each further packet sent while still in it.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tx_start_q <= 1'b0;
    end else if (i_enable) begin
      tx_start_q <= (mode_d == radio_mode_pkg::MODE_TX)
                    && (mode_q != radio_mode_pkg::MODE_TX || tx_pop);
    end
  end

  // Read data, valid the cycle after the read strobe.
  wire logic [7:0] status_word = {rx_drop_q, rx_full, tx_empty, power_flag_q, 1'b0,
                                  mode_q};
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 8'h00;
    end else if (i_enable) begin
      if (i_read) begin
        unique case (i_addr)
          radio_mode_pkg::ADDR_CONTROL: rdata_q <= {5'h00, ctrl_q};
          radio_mode_pkg::ADDR_STATUS: rdata_q <= status_word;
          radio_mode_pkg::ADDR_RX_POP: rdata_q <= {6'h00, rx_count_q};
          default: rdata_q <= 8'h00;
        endcase
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign o_rdata = rdata_q;
  assign o_mode = mode_q;
  assign o_radio_on = (mode_q == radio_mode_pkg::MODE_RX) || (mode_q == radio_mode_pkg::MODE_TX);
  assign o_tx_start = tx_start_q;
  assign o_received_power_flag = power_flag_q;

  a_por_exit: assert property (@(posedge i_clock) disable iff (i_rst)
    (mode_q == radio_mode_pkg::MODE_POR && mode_d != radio_mode_pkg::MODE_POR)
    |-> timer_q >= 32'(POR_COUNT - 1))
    else $error("Power-on reset left too early.");
  a_power_down: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_enable && !ctrl_q.power_up && mode_q != radio_mode_pkg::MODE_POR)
    |=> mode_q == radio_mode_pkg::MODE_POWER_DOWN)
    else $error("Power-up low did not force power-down.");
  a_wake_standby: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_enable && mode_q == radio_mode_pkg::MODE_POWER_DOWN && ctrl_q.power_up)
    |=> mode_q == radio_mode_pkg::MODE_STANDBY1)
    else $error("Power-up did not reach first standby.");
  a_rx_entry: assert property (@(posedge i_clock) disable iff (i_rst)
    (mode_q != radio_mode_pkg::MODE_RX_SETTLE && mode_d == radio_mode_pkg::MODE_RX_SETTLE)
    |-> ctrl_q.primary_rx && act_pin && ctrl_q.power_up)
    else $error("Receive entered without all three conditions.");
  a_active_pin: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_enable && mode_q == radio_mode_pkg::MODE_RX && !act_pin && ctrl_q.power_up)
    |=> mode_q == radio_mode_pkg::MODE_STANDBY1)
    else $error("Receive did not drop to standby on pin low.");
  a_rx_drop: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_enable && rx_valid && rx_full && !rd_pop) |=> rx_full && rx_drop_q)
    else $error("Packet stored into a full receive queue.");
  a_flag_filter: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(power_flag_q) |-> $past(filt_q) >= 32'(FILTER_COUNT - 1))
    else $error("Power flag rose before the filter time.");
  a_tx_limit: assert property (@(posedge i_clock) disable iff (i_rst)
    ctrl_q.auto_proto |-> tx_time_q < 32'(TX_LIMIT_COUNT))
    else $error("Transmit dwell exceeded the limit.");
  a_settle_time: assert property (@(posedge i_clock) disable iff (i_rst)
    mode_q == radio_mode_pkg::MODE_TX_SETTLE |-> timer_q < 32'(SETTLE_COUNT))
    else $error("Settling exceeded its limit.");

  // Steps of the transmit path, from a queued payload to the end of a packet.
  sequence s_sb2_load;
    i_enable && mode_q == radio_mode_pkg::MODE_STANDBY2 && act_pin && ctrl_q.power_up
    && !ctrl_q.primary_rx && !tx_empty;
  endsequence
  sequence s_tx_settled;
    i_enable && mode_q == radio_mode_pkg::MODE_TX_SETTLE && settled && ctrl_q.power_up;
  endsequence
  sequence s_tx_end_low;
    i_enable && mode_q == radio_mode_pkg::MODE_TX && tx_pop && !act_pin && ctrl_q.power_up;
  endsequence
  sequence s_tx_more;
    i_enable && mode_q == radio_mode_pkg::MODE_TX && tx_pop && act_pin && ctrl_q.power_up
    && !ctrl_q.primary_rx && tx_count_q > SLOT_W'(1) && !tx_overrun;
  endsequence
  sequence s_tx_last;
    i_enable && mode_q == radio_mode_pkg::MODE_TX && tx_pop && act_pin && ctrl_q.power_up
    && !ctrl_q.primary_rx && tx_count_q == SLOT_W'(1);
  endsequence

  a_tx_entry: assert property (@(posedge i_clock) disable iff (i_rst)
    (mode_q != radio_mode_pkg::MODE_TX_SETTLE && mode_d == radio_mode_pkg::MODE_TX_SETTLE)
    |-> ctrl_q.power_up && !ctrl_q.primary_rx && !tx_empty)
    else $error("Transmit entered without a queued payload.");
  a_sb2_wake: assert property (@(posedge i_clock) disable iff (i_rst)
    s_sb2_load |=> mode_q == radio_mode_pkg::MODE_TX_SETTLE)
    else $error("Queued packet did not start the synthesizer.");
  a_tx_launch: assert property (@(posedge i_clock) disable iff (i_rst)
    s_tx_settled |=> mode_q == radio_mode_pkg::MODE_TX && tx_start_q)
    else $error("Settled synthesizer did not start the packet.");
  a_tx_end_low: assert property (@(posedge i_clock) disable iff (i_rst)
    s_tx_end_low |=> mode_q == radio_mode_pkg::MODE_STANDBY1)
    else $error("Finished packet with pin low did not reach first standby.");
  a_tx_next: assert property (@(posedge i_clock) disable iff (i_rst)
    s_tx_more |=> mode_q == radio_mode_pkg::MODE_TX && tx_start_q)
    else $error("Queued packet was not sent next.");
  a_tx_drain: assert property (@(posedge i_clock) disable iff (i_rst)
    s_tx_last |=> mode_q == radio_mode_pkg::MODE_STANDBY2)
    else $error("Empty queue did not lead to second standby.");

  // Receive hold, second standby entry, flag and storage.
  a_sb2_entry: assert property (@(posedge i_clock) disable iff (i_rst)
    (mode_q != radio_mode_pkg::MODE_STANDBY2 && mode_d == radio_mode_pkg::MODE_STANDBY2)
    |-> act_pin && !ctrl_q.primary_rx && ctrl_q.power_up)
    else $error("Second standby entered without its conditions.");
  a_rx_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_enable && mode_q == radio_mode_pkg::MODE_RX && act_pin && ctrl_q.primary_rx
    && ctrl_q.power_up) |=> mode_q == radio_mode_pkg::MODE_RX)
    else $error("Receive mode left without a command.");
  a_flag_held: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_enable && mode_q != radio_mode_pkg::MODE_RX) |=> $stable(power_flag_q))
    else $error("Power flag changed outside receive mode.");
  a_rx_store: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_enable && rx_store && !rd_pop) |=> rx_count_q == $past(rx_count_q) + SLOT_W'(1))
    else $error("Valid packet was not stored in a free slot.");
  a_ctrl_write: assert property (@(posedge i_clock) disable iff (i_rst)
    wr_ctrl |=> ctrl_q.power_up == $past(i_wdata[radio_mode_pkg::CTRL_POWER_UP]))
    else $error("Control write did not land.");

endmodule

/* File: test/host_pin_model.sv */
/*
  Host-side pin model: drives the activate pin and the strong-signal detect line.
  Assumes the bench sets the requested levels; pins follow on an 80 ns host clock.
*/
`timescale 1ns/10ps
module host_pin_model (
  // Requests from the bench.
  input wire logic i_act_req,
  input wire logic i_pwr_req,
  // Pins toward the radio.
  output logic o_activate,
  output logic o_power_detect
);
  logic link_clk;

  initial begin
    link_clk = 1'b0;
    o_activate = 1'b0;
    o_power_detect = 1'b0;
    #3;
    forever #40 link_clk = ~link_clk;
  end

  // The pins change only on the host's own clock, unrelated to the radio clock.
  always @(posedge link_clk) begin
    o_activate <= i_act_req;
    o_power_detect <= i_pwr_req;
  end
endmodule

/* File: test/tb_top.sv */
/*
  Self-checking bench for the radio mode controller.
  Assumes the host pin model drives the activate and detect pins.
*/
`timescale 1ns/10ps
module tb_top;
  localparam int POR_N = 20;
  localparam int SET_N = 10;
  localparam int FLT_N = 8;
  localparam int TXL_N = 50;
  localparam int ACT_N = radio_mode_pkg::ACTIVATE_PULSE_CYCLES;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic act_req = 1'b0;
  logic pwr_req = 1'b0;
  logic rx_pkt = 1'b0;
  logic rx_match = 1'b0;
  logic rx_crc = 1'b0;
  logic tx_done = 1'b0;
  logic activate;
  logic power_detect;
  logic [7:0] rdata;
  radio_mode_pkg::mode_e mode;
  logic radio_on;
  logic tx_start;
  logic pwr_flag;
  int bad_count = 0;
  int tests_run = 0;
  int starts = 0;
  logic [31:0] seed = 32'h000000EC;

  host_pin_model host (.i_act_req(act_req), .i_pwr_req(pwr_req), .o_activate(activate),
    .o_power_detect(power_detect));

  radio_mode_controller #(.POR_COUNT(POR_N), .SETTLE_COUNT(SET_N), .FILTER_COUNT(FLT_N),
    .TX_LIMIT_COUNT(TXL_N)) DUT (.i_clock(clock), .i_rst(rst), .i_enable(en),
    .i_addr(addr), .i_wdata(wdata), .i_write(wr_s), .i_read(rd_s), .o_rdata(rdata),
    .i_activate(activate), .i_power_detect(power_detect), .i_rx_packet(rx_pkt),
    .i_rx_addr_match(rx_match), .i_rx_crc_ok(rx_crc), .i_tx_done(tx_done), .o_mode(mode),
    .o_radio_on(radio_on), .o_tx_start(tx_start), .o_received_power_flag(pwr_flag));

  initial begin
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (tx_start === 1'b1) starts <= starts + 1;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] exp_count(int v);
    return (v > radio_mode_pkg::RX_SLOTS) ? 8'(radio_mode_pkg::RX_SLOTS) : 8'(v);
  endfunction

  task automatic wrap_up();
    if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(logic [7:0] g, logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wait_mode(radio_mode_pkg::mode_e m, int lim);
    int i;
    i = 0;
    #1;
    while (mode !== m && i < lim) begin
      cyc(1);
      i++;
    end
    chk(8'(mode), 8'(m));
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clock);
    wr_s <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic pkt(logic m, logic c);
    @(posedge clock);
    rx_pkt <= 1'b1;
    rx_match <= m;
    rx_crc <= c;
    @(posedge clock);
    rx_pkt <= 1'b0;
  endtask

  task automatic done();
    @(posedge clock);
    tx_done <= 1'b1;
    @(posedge clock);
    tx_done <= 1'b0;
  endtask

  task automatic tx_entry(logic [7:0] ctl);
    wr(radio_mode_pkg::ADDR_CONTROL, ctl);
    wr(radio_mode_pkg::ADDR_TX_LOAD, 8'h00);
    act_req <= 1'b1;
    wait_mode(radio_mode_pkg::MODE_TX_SETTLE, ACT_N + 30);
    wait_mode(radio_mode_pkg::MODE_TX, SET_N + 3);
  endtask

  initial begin
    #300000;
    bad_count++;
    wrap_up();
  end

  initial begin
    logic [7:0] d;
    logic [31:0] r;
    logic m;
    logic c;
    int v;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    cyc(1);
    chk(8'(mode), 8'(radio_mode_pkg::MODE_POR));
    cyc(POR_N / 2);
    chk(8'(mode), 8'(radio_mode_pkg::MODE_POR));
    wait_mode(radio_mode_pkg::MODE_POWER_DOWN, POR_N + 5);
    chk(8'(radio_on), 8'h00);
    rd(radio_mode_pkg::ADDR_CONTROL, d);
    chk(d, radio_mode_pkg::CTRL_RESET);
    wr(radio_mode_pkg::ADDR_CONTROL, 8'h03);
    wait_mode(radio_mode_pkg::MODE_STANDBY1, 3);
    rd(radio_mode_pkg::ADDR_CONTROL, d);
    chk(d, 8'h03);
    rd(radio_mode_pkg::ADDR_STATUS, d);
    chk(8'(d[2:0]), 8'(radio_mode_pkg::MODE_STANDBY1));
    rd(4'hF, d);
    chk(d, 8'h00);
    cyc(5);
    act_req <= 1'b1;
    wait_mode(radio_mode_pkg::MODE_RX_SETTLE, 20);
    wait_mode(radio_mode_pkg::MODE_RX, SET_N + 3);
    chk(8'(radio_on), 8'h01);
    pwr_req <= 1'b1;
    cyc(4);
    chk(8'(pwr_flag), 8'h00);
    cyc(FLT_N + 20);
    chk(8'(pwr_flag), 8'h01);
    rd(radio_mode_pkg::ADDR_STATUS, d);
    chk(8'(d[radio_mode_pkg::STAT_POWER_FLAG]), 8'h01);
    v = 0;
    for (int k = 0; k < 10; k++) begin
      r = xs();
      m = (k > 5) | r[0];
      c = (k > 5) | r[1];
      pkt(m, c);
      v += int'(m & c);
    end
    chk(8'(mode), 8'(radio_mode_pkg::MODE_RX));
    rd(radio_mode_pkg::ADDR_STATUS, d);
    chk(8'(d[7:6]), 8'h03);
    rd(radio_mode_pkg::ADDR_RX_POP, d);
    chk(d, exp_count(v));
    rd(radio_mode_pkg::ADDR_STATUS, d);
    chk(8'(d[7:6]), 8'h00);
    wr(radio_mode_pkg::ADDR_TX_LOAD, 8'h00);
    wr(radio_mode_pkg::ADDR_CONTROL, 8'h01);
    wait_mode(radio_mode_pkg::MODE_TX_SETTLE, 3);
    wait_mode(radio_mode_pkg::MODE_TX, SET_N + 3);
    done();
    wait_mode(radio_mode_pkg::MODE_STANDBY2, 3);
    act_req <= 1'b0;
    pwr_req <= 1'b0;
    wait_mode(radio_mode_pkg::MODE_STANDBY1, 20);
    tx_entry(8'h01);
    cyc(2);
    chk(8'(starts), 8'h02);
    done();
    wait_mode(radio_mode_pkg::MODE_STANDBY2, 3);
    wr(radio_mode_pkg::ADDR_TX_LOAD, 8'h00);
    wait_mode(radio_mode_pkg::MODE_TX_SETTLE, 3);
    wait_mode(radio_mode_pkg::MODE_TX, SET_N + 3);
    wr(radio_mode_pkg::ADDR_TX_LOAD, 8'h00);
    done();
    cyc(SET_N + 5);
    chk(8'(mode), 8'(radio_mode_pkg::MODE_TX));
    chk(8'(starts), 8'h04);
    act_req <= 1'b0;
    cyc(15);
    done();
    wait_mode(radio_mode_pkg::MODE_STANDBY1, 3);
    tx_entry(8'h05);
    wait_mode(radio_mode_pkg::MODE_STANDBY2, TXL_N + 5);
    wr(radio_mode_pkg::ADDR_CONTROL, 8'h00);
    wait_mode(radio_mode_pkg::MODE_POWER_DOWN, 3);
    act_req <= 1'b0;
    en <= 1'b0;
    wr(radio_mode_pkg::ADDR_CONTROL, 8'h03);
    cyc(3);
    chk(8'(mode), 8'(radio_mode_pkg::MODE_POWER_DOWN));
    en <= 1'b1;
    rd(radio_mode_pkg::ADDR_CONTROL, d);
    chk(d, 8'h00);
    wrap_up();
  end
endmodule
